// >>> shared/lvs_pkg.sv
// shared constants and types for the four-channel linear regulator control
package lvs_pkg;
   localparam int NUM_CHAN = 4;
   localparam int CODE_W = 4;
   localparam int MV_W = 13;
   localparam int HW_CHAN = 1;
   localparam logic ENABLE_RST = 1'b0;
   localparam logic ILIM_RST = 1'b0;
   localparam logic OUT_RST = 1'b0;
   localparam logic PULL_DOWN_RST = 1'b1;
   localparam logic [CODE_W-1:0] CODE_RST = 4'h0;

   // system state handed over by the power sequencer
   typedef enum logic [1:0] {
      LVS_SYS_OFF,
      LVS_SYS_RUN,
      LVS_SYS_SLEEP,
      LVS_SYS_QUICK_POWERUP_OFF_STATE
   } lvs_sys_state_e;

   // field written by a software write strobe
   typedef enum logic [2:0] {
      LVS_FLD_ACTIVE_EN,
      LVS_FLD_SLEEP_EN,
      LVS_FLD_ACTIVE_CODE,
      LVS_FLD_SLEEP_CODE,
      LVS_FLD_ILIM_EN
   } lvs_field_e;

   // output voltage in millivolts per code
   localparam logic [MV_W-1:0] MV_0000 = 13'h05dc;
   localparam logic [MV_W-1:0] MV_0001 = 13'h0640;
   localparam logic [MV_W-1:0] MV_0010 = 13'h0708;
   localparam logic [MV_W-1:0] MV_0011 = 13'h073a;
   localparam logic [MV_W-1:0] MV_0100 = 13'h0866;
   localparam logic [MV_W-1:0] MV_0101 = 13'h09c4;
   localparam logic [MV_W-1:0] MV_0110 = 13'h0af0;
   localparam logic [MV_W-1:0] MV_0111 = 13'h0bb8;
   localparam logic [MV_W-1:0] MV_1000 = 13'h0c1c;
   localparam logic [MV_W-1:0] MV_1001 = 13'h0c4e;
   localparam logic [MV_W-1:0] MV_1010 = 13'h0c80;
   localparam logic [MV_W-1:0] MV_1011 = 13'h0ce4;
   localparam logic [MV_W-1:0] MV_1100 = 13'h0d16;
   localparam logic [MV_W-1:0] MV_1101 = 13'h0672;
   localparam logic [MV_W-1:0] MV_1110 = 13'h06a4;
   localparam logic [MV_W-1:0] MV_1111 = 13'h1388;
endpackage

// >>> rtl/lvs_volt_decode.sv
// voltage code to millivolt lookup
`timescale 1ns/10ps
module lvs_volt_decode
(
   input wire logic [lvs_pkg::CODE_W-1:0] code,
   output logic [lvs_pkg::MV_W-1:0] millivolts
);
   always_comb
   begin
      case (code) // see R9
         4'h0: millivolts = lvs_pkg::MV_0000;
         4'h1: millivolts = lvs_pkg::MV_0001;
         4'h2: millivolts = lvs_pkg::MV_0010;
         4'h3: millivolts = lvs_pkg::MV_0011;
         4'h4: millivolts = lvs_pkg::MV_0100;
         4'h5: millivolts = lvs_pkg::MV_0101;
         4'h6: millivolts = lvs_pkg::MV_0110;
         4'h7: millivolts = lvs_pkg::MV_0111;
         4'h8: millivolts = lvs_pkg::MV_1000;
         4'h9: millivolts = lvs_pkg::MV_1001;
         4'ha: millivolts = lvs_pkg::MV_1010;
         4'hb: millivolts = lvs_pkg::MV_1011;
         4'hc: millivolts = lvs_pkg::MV_1100;
         4'hd: millivolts = lvs_pkg::MV_1101;
         4'he: millivolts = lvs_pkg::MV_1110;
         default: millivolts = lvs_pkg::MV_1111;
      endcase
   end
endmodule

// >>> rtl/lvs_chan_mode.sv
// per-channel operating mode from state, enable and fused option
`timescale 1ns/10ps
module lvs_chan_mode
(
   input wire lvs_pkg::lvs_sys_state_e sysState,
   input wire logic chanSwitchEnable,
   input wire logic fusedPassSwitchOption,
   input wire logic switchCurrentLimitEnable,
   input wire logic tryBeforeBuyEnable,
   output logic outOn,
   output logic outRegulate,
   output logic outPassThrough,
   output logic outPullDown,
   output logic outWeakPullDown,
   output logic outCurrentLimit
);
   wire logic quickOff;

   // weak pull-down replaces the normal one only in quick power-up off
   assign quickOff = tryBeforeBuyEnable && (sysState == lvs_pkg::LVS_SYS_QUICK_POWERUP_OFF_STATE); // see R14
   assign outOn = chanSwitchEnable; // see R12
   assign outRegulate = chanSwitchEnable && !fusedPassSwitchOption; // see R5
   assign outPassThrough = chanSwitchEnable && fusedPassSwitchOption; // see R11
   assign outPullDown = !chanSwitchEnable && !quickOff; // see R4
   assign outWeakPullDown = !chanSwitchEnable && quickOff; // see R14
   assign outCurrentLimit = outPassThrough && switchCurrentLimitEnable; // see R13
endmodule

// >>> rtl/lvs_ldo_ctrl.sv
// control for four linear regulator channels: enables, voltage codes, modes
// Operation
// R1: channel is off in run state when its run enable bit is 0.
// R2: channel is off in standby state when its standby enable bit is 0.
// R3: power-up sequence sets both enables for members, clears them otherwise.
// R4: disabled channel is off with output pull-down, regardless of fused option.
// R5: enabled channel regulates, or acts as load switch when option fused.
// R6: run-state output voltage comes from the four-bit run code.
// R7: standby output voltage comes from the separate four-bit standby code.
// R8: power-up loads both codes from each channel's fused default code.
// R9: code decodes to fixed table from 1.5 V to 5.0 V.
// R10: second channel may follow hardware enable and voltage select pins.
// R11: fused load-switch option passes input straight to output.
// R12: in load-switch mode the channel enable opens or closes switch.
// R13: enabled load switch is current limited only when limit bit is 1.
// R14: try-before-buy in quick power-up off selects weaker pull-down.
// R15: outputs follow enable and code of current state, updating on change.
`timescale 1ns/10ps
module lvs_ldo_ctrl
#(
   parameter int NUM_CHAN = lvs_pkg::NUM_CHAN
)
(
   input wire logic clk,
   input wire logic reset,
   input wire lvs_pkg::lvs_sys_state_e sysState,
   input wire logic powerUpLoadCodes,
   input wire logic powerUpSequence,
   input wire logic [NUM_CHAN-1:0] seqMember,
   input wire logic [NUM_CHAN-1:0] fusedPassSwitchOption,
   input wire logic [NUM_CHAN*lvs_pkg::CODE_W-1:0] fusedDefaultVoltageCode,
   input wire logic fusedHwSecondChanControl,
   input wire logic tryBeforeBuyEnable,
   input wire logic hwSecondChanEnablePin,
   input wire logic hwVoltageChoicePin,
   input wire logic swWrite,
   input wire logic [1:0] swChan,
   input wire lvs_pkg::lvs_field_e swField,
   input wire logic [lvs_pkg::CODE_W-1:0] swData,
   output logic [NUM_CHAN-1:0] chanActiveStateEnable,
   output logic [NUM_CHAN-1:0] chanSleepStateEnable,
   output logic [NUM_CHAN-1:0] switchCurrentLimitEnable,
   output logic [NUM_CHAN*lvs_pkg::CODE_W-1:0] chanActiveVoltageCode,
   output logic [NUM_CHAN*lvs_pkg::CODE_W-1:0] chanSleepVoltageCode,
   output logic [NUM_CHAN-1:0] chanOn,
   output logic [NUM_CHAN-1:0] chanRegulate,
   output logic [NUM_CHAN-1:0] chanPassThrough,
   output logic [NUM_CHAN-1:0] chanPullDown,
   output logic [NUM_CHAN-1:0] chanWeakPullDown,
   output logic [NUM_CHAN-1:0] chanCurrentLimit,
   output logic [NUM_CHAN*lvs_pkg::CODE_W-1:0] chanVoltCode,
   output logic [NUM_CHAN*lvs_pkg::MV_W-1:0] chanMillivolts
);
   localparam int CW = lvs_pkg::CODE_W;
   localparam int MW = lvs_pkg::MV_W;

   wire logic inRun;
   wire logic inSleep;

   assign inRun = (sysState == lvs_pkg::LVS_SYS_RUN);
   assign inSleep = (sysState == lvs_pkg::LVS_SYS_SLEEP);

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CHAN; gi = gi + 1)
      begin : g_chan
         logic activeEn_r;
         logic activeEn_nxt;
         logic sleepEn_r;
         logic sleepEn_nxt;
         logic ilimEn_r;
         logic ilimEn_nxt;
         logic [CW-1:0] activeCode_r;
         logic [CW-1:0] activeCode_nxt;
         logic [CW-1:0] sleepCode_r;
         logic [CW-1:0] sleepCode_nxt;
         logic on_r;
         logic regulate_r;
         logic pass_r;
         logic pullDown_r;
         logic weakPullDown_r;
         logic curLimit_r;
         logic [CW-1:0] code_r;
         logic [MW-1:0] mv_r;
         wire logic hit;
         wire logic hwCtrl;
         wire logic swEnable;
         wire logic selEnable;
         wire logic [CW-1:0] swCode;
         wire logic [CW-1:0] selCode;
         wire logic [MW-1:0] selMv;
         wire logic modeOn;
         wire logic modeReg;
         wire logic modePass;
         wire logic modePd;
         wire logic modeWeakPd;
         wire logic modeIlim;

         assign hit = swWrite && (swChan == 2'(gi));

         // sequencer and fuse loads beat a software write in the same cycle
         assign activeEn_nxt = powerUpSequence ? seqMember[gi] : // see R3
            (hit && swField == lvs_pkg::LVS_FLD_ACTIVE_EN) ? swData[0] : activeEn_r;
         assign sleepEn_nxt = powerUpSequence ? seqMember[gi] : // see R3
            (hit && swField == lvs_pkg::LVS_FLD_SLEEP_EN) ? swData[0] : sleepEn_r;
         assign ilimEn_nxt = (hit && swField == lvs_pkg::LVS_FLD_ILIM_EN) ? swData[0] : ilimEn_r;
         assign activeCode_nxt = powerUpLoadCodes ? fusedDefaultVoltageCode[gi*CW +: CW] : // see R8
            (hit && swField == lvs_pkg::LVS_FLD_ACTIVE_CODE) ? swData : activeCode_r;
         assign sleepCode_nxt = powerUpLoadCodes ? fusedDefaultVoltageCode[gi*CW +: CW] : // see R8
            (hit && swField == lvs_pkg::LVS_FLD_SLEEP_CODE) ? swData : sleepCode_r;

         // pin control only exists on the second channel; the enable pin counts only in run or standby, the voltage pin in every state
         assign hwCtrl = (gi == lvs_pkg::HW_CHAN) && fusedHwSecondChanControl;
         assign swEnable = (inRun && activeEn_r) || (inSleep && sleepEn_r); // see R1 R2 R15
         assign selEnable = hwCtrl ? (hwSecondChanEnablePin && (inRun || inSleep)) : swEnable; // see R10
         assign swCode = inSleep ? sleepCode_r : activeCode_r; // see R6 R7 R15
         assign selCode = hwCtrl ? (hwVoltageChoicePin ? sleepCode_r : activeCode_r) : swCode; // see R10

         lvs_chan_mode u_mode
         (
            .sysState(sysState),
            .chanSwitchEnable(selEnable),
            .fusedPassSwitchOption(fusedPassSwitchOption[gi]),
            .switchCurrentLimitEnable(ilimEn_r),
            .tryBeforeBuyEnable(tryBeforeBuyEnable),
            .outOn(modeOn),
            .outRegulate(modeReg),
            .outPassThrough(modePass),
            .outPullDown(modePd),
            .outWeakPullDown(modeWeakPd),
            .outCurrentLimit(modeIlim)
         );

         lvs_volt_decode u_dec
         (
            .code(selCode),
            .millivolts(selMv)
         );

         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               activeEn_r <= lvs_pkg::ENABLE_RST;
               sleepEn_r <= lvs_pkg::ENABLE_RST;
               ilimEn_r <= lvs_pkg::ILIM_RST;
               activeCode_r <= lvs_pkg::CODE_RST;
               sleepCode_r <= lvs_pkg::CODE_RST;
            end
            else
            begin
               activeEn_r <= activeEn_nxt;
               sleepEn_r <= sleepEn_nxt;
               ilimEn_r <= ilimEn_nxt;
               activeCode_r <= activeCode_nxt;
               sleepCode_r <= sleepCode_nxt;
            end
         end

         // registered outputs lag the state and bits by one cycle
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               on_r <= lvs_pkg::OUT_RST;
               regulate_r <= lvs_pkg::OUT_RST;
               pass_r <= lvs_pkg::OUT_RST;
               pullDown_r <= lvs_pkg::PULL_DOWN_RST;
               weakPullDown_r <= lvs_pkg::OUT_RST;
               curLimit_r <= lvs_pkg::OUT_RST;
               code_r <= lvs_pkg::CODE_RST;
               mv_r <= lvs_pkg::MV_0000;
            end
            else
            begin
               on_r <= modeOn; // see R1 R2
               regulate_r <= modeReg; // see R5
               pass_r <= modePass; // see R11
               pullDown_r <= modePd; // see R4
               weakPullDown_r <= modeWeakPd; // see R14
               curLimit_r <= modeIlim; // see R13
               code_r <= selCode; // see R15
               mv_r <= selMv; // see R9
            end
         end

         assign chanActiveStateEnable[gi] = activeEn_r;
         assign chanSleepStateEnable[gi] = sleepEn_r;
         assign switchCurrentLimitEnable[gi] = ilimEn_r;
         assign chanActiveVoltageCode[gi*CW +: CW] = activeCode_r;
         assign chanSleepVoltageCode[gi*CW +: CW] = sleepCode_r;
         assign chanOn[gi] = on_r;
         assign chanRegulate[gi] = regulate_r;
         assign chanPassThrough[gi] = pass_r;
         assign chanPullDown[gi] = pullDown_r;
         assign chanWeakPullDown[gi] = weakPullDown_r;
         assign chanCurrentLimit[gi] = curLimit_r;
         assign chanVoltCode[gi*CW +: CW] = code_r;
         assign chanMillivolts[gi*MW +: MW] = mv_r;
      end
   endgenerate
endmodule

// >>> test/lvs_otp_model.sv
// fuse and sequencer table model feeding the regulator control
`timescale 1ns/10ps
module lvs_otp_model
#(
   parameter logic [3:0] MEMBER = 4'h5,
   parameter logic [3:0] PASS = 4'h4,
   parameter logic [15:0] DEFCODE = 16'hf0d5
)
(
   output logic [3:0] seqMember,
   output logic [3:0] fusedPassSwitchOption,
   output logic [15:0] fusedDefaultVoltageCode
);
   // fuses are static, so plain levels are all the far side gives
   assign seqMember = MEMBER;
   assign fusedPassSwitchOption = PASS;
   assign fusedDefaultVoltageCode = DEFCODE;
endmodule

// >>> test/lvs_ldo_ctrl_chk.sv
// concurrent checks on the regulator control ports
`timescale 1ns/10ps
module lvs_ldo_ctrl_chk
#(
   parameter int NUM_CHAN = 4
)
(
   input wire logic clk,
   input wire logic reset,
   input wire lvs_pkg::lvs_sys_state_e sysState,
   input wire logic powerUpLoadCodes,
   input wire logic powerUpSequence,
   input wire logic [NUM_CHAN-1:0] seqMember,
   input wire logic [NUM_CHAN-1:0] fusedPassSwitchOption,
   input wire logic [NUM_CHAN*4-1:0] fusedDefaultVoltageCode,
   input wire logic tryBeforeBuyEnable,
   input wire logic [NUM_CHAN-1:0] chanActiveStateEnable,
   input wire logic [NUM_CHAN-1:0] switchCurrentLimitEnable,
   input wire logic [NUM_CHAN*4-1:0] chanActiveVoltageCode,
   input wire logic [NUM_CHAN*4-1:0] chanSleepVoltageCode,
   input wire logic [NUM_CHAN-1:0] chanOn,
   input wire logic [NUM_CHAN-1:0] chanRegulate,
   input wire logic [NUM_CHAN-1:0] chanPassThrough,
   input wire logic [NUM_CHAN-1:0] chanPullDown,
   input wire logic [NUM_CHAN-1:0] chanWeakPullDown,
   input wire logic [NUM_CHAN-1:0] chanCurrentLimit,
   input wire logic [NUM_CHAN*4-1:0] chanVoltCode
);
   // pin-driven channel masked out, its enable comes from a pin
   localparam logic [NUM_CHAN-1:0] SWM = ~(NUM_CHAN'(1) << lvs_pkg::HW_CHAN);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_run;
      sysState == lvs_pkg::LVS_SYS_RUN;
   endsequence
   sequence s_sleep;
      sysState == lvs_pkg::LVS_SYS_SLEEP;
   endsequence
   a_run_enable: assert property (s_run |=>
      (chanOn & SWM) == ($past(chanActiveStateEnable) & SWM) && (chanPullDown & SWM) == (~chanOn & SWM))
      else $error("run enable mismatch");
   a_run_mode: assert property (s_run |=>
      chanRegulate == (chanOn & ~$past(fusedPassSwitchOption)) && chanPassThrough == (chanOn & $past(fusedPassSwitchOption)))
      else $error("channel mode mismatch");
   a_ilim_gate: assert property (s_run |=> chanCurrentLimit == (chanPassThrough & $past(switchCurrentLimitEnable)))
      else $error("current limit mismatch");
   a_run_code: assert property (s_run |=> chanVoltCode[3:0] == $past(chanActiveVoltageCode[3:0]))
      else $error("run code mismatch");
   a_sleep_code: assert property (s_sleep |=> chanVoltCode[3:0] == $past(chanSleepVoltageCode[3:0]))
      else $error("sleep code mismatch");
   a_seq_sets: assert property (powerUpSequence |=> chanActiveStateEnable == $past(seqMember))
      else $error("sequence enable mismatch");
   a_load_codes: assert property (powerUpLoadCodes |=>
      chanActiveVoltageCode == $past(fusedDefaultVoltageCode) && chanSleepVoltageCode == $past(fusedDefaultVoltageCode))
      else $error("default code load mismatch");
   a_weak_pd: assert property (tryBeforeBuyEnable && sysState == lvs_pkg::LVS_SYS_QUICK_POWERUP_OFF_STATE |=>
      chanWeakPullDown == '1 && chanPullDown == '0) else $error("weak pull-down mismatch");
endmodule

bind lvs_ldo_ctrl lvs_ldo_ctrl_chk #(.NUM_CHAN(NUM_CHAN)) i_chk
(
   .clk(clk),
   .reset(reset),
   .sysState(sysState),
   .powerUpLoadCodes(powerUpLoadCodes),
   .powerUpSequence(powerUpSequence),
   .seqMember(seqMember),
   .fusedPassSwitchOption(fusedPassSwitchOption),
   .fusedDefaultVoltageCode(fusedDefaultVoltageCode),
   .tryBeforeBuyEnable(tryBeforeBuyEnable),
   .chanActiveStateEnable(chanActiveStateEnable),
   .switchCurrentLimitEnable(switchCurrentLimitEnable),
   .chanActiveVoltageCode(chanActiveVoltageCode),
   .chanSleepVoltageCode(chanSleepVoltageCode),
   .chanOn(chanOn),
   .chanRegulate(chanRegulate),
   .chanPassThrough(chanPassThrough),
   .chanPullDown(chanPullDown),
   .chanWeakPullDown(chanWeakPullDown),
   .chanCurrentLimit(chanCurrentLimit),
   .chanVoltCode(chanVoltCode)
);

// >>> test/tb.sv
// self-checking bench for the regulator control block
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb;
   logic clk = 1'b0, reset = 1'b1, powerUpLoadCodes = 1'b0, powerUpSequence = 1'b0, fusedHwSecondChanControl = 1'b0;
   logic tryBeforeBuyEnable = 1'b0, hwSecondChanEnablePin = 1'b0, hwVoltageChoicePin = 1'b0, swWrite = 1'b0;
   lvs_pkg::lvs_sys_state_e sysState = lvs_pkg::LVS_SYS_OFF;
   lvs_pkg::lvs_field_e swField = lvs_pkg::LVS_FLD_ACTIVE_EN;
   logic [1:0] swChan = 2'h0;
   logic [3:0] swData = 4'h0;
   logic [3:0] seqMember, fusedPassSwitchOption, chanActiveStateEnable, chanSleepStateEnable, switchCurrentLimitEnable;
   logic [3:0] chanOn, chanRegulate, chanPassThrough, chanPullDown, chanWeakPullDown, chanCurrentLimit;
   logic [15:0] fusedDefaultVoltageCode, chanActiveVoltageCode, chanSleepVoltageCode, chanVoltCode;
   logic [51:0] chanMillivolts;
   logic [12:0] mv [16] = '{13'h5dc, 13'h640, 13'h708, 13'h73a, 13'h866, 13'h9c4, 13'haf0, 13'hbb8,
      13'hc1c, 13'hc4e, 13'hc80, 13'hce4, 13'hd16, 13'h672, 13'h6a4, 13'h1388};
   int error_cnt = 0, tests_run = 0;
   lvs_otp_model i_otp
   (
      .seqMember(seqMember),
      .fusedPassSwitchOption(fusedPassSwitchOption),
      .fusedDefaultVoltageCode(fusedDefaultVoltageCode)
   );
   lvs_ldo_ctrl i_dut
   (
      .clk(clk),
      .reset(reset),
      .sysState(sysState),
      .powerUpLoadCodes(powerUpLoadCodes),
      .powerUpSequence(powerUpSequence),
      .seqMember(seqMember),
      .fusedPassSwitchOption(fusedPassSwitchOption),
      .fusedDefaultVoltageCode(fusedDefaultVoltageCode),
      .fusedHwSecondChanControl(fusedHwSecondChanControl),
      .tryBeforeBuyEnable(tryBeforeBuyEnable),
      .hwSecondChanEnablePin(hwSecondChanEnablePin),
      .hwVoltageChoicePin(hwVoltageChoicePin),
      .swWrite(swWrite),
      .swChan(swChan),
      .swField(swField),
      .swData(swData),
      .chanActiveStateEnable(chanActiveStateEnable),
      .chanSleepStateEnable(chanSleepStateEnable),
      .switchCurrentLimitEnable(switchCurrentLimitEnable),
      .chanActiveVoltageCode(chanActiveVoltageCode),
      .chanSleepVoltageCode(chanSleepVoltageCode),
      .chanOn(chanOn),
      .chanRegulate(chanRegulate),
      .chanPassThrough(chanPassThrough),
      .chanPullDown(chanPullDown),
      .chanWeakPullDown(chanWeakPullDown),
      .chanCurrentLimit(chanCurrentLimit),
      .chanVoltCode(chanVoltCode),
      .chanMillivolts(chanMillivolts)
   );
   always #5 clk = ~clk;
   // outputs stand, so a fixed wait past the two-cycle answer is safe
   task settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task wr(input logic [1:0] c, input lvs_pkg::lvs_field_e f, input logic [3:0] d);
      @(posedge clk);
      swWrite <= 1'b1;
      swChan <= c;
      swField <= f;
      swData <= d;
      @(posedge clk);
      swWrite <= 1'b0;
   endtask
   task t_powerup;
      settle;
      `CHK(chanPullDown, 4'hf)
      `CHK(chanMillivolts, {4{13'h05dc}})
      @(posedge clk);
      powerUpSequence <= 1'b1;
      powerUpLoadCodes <= 1'b1;
      @(posedge clk);
      powerUpSequence <= 1'b0;
      powerUpLoadCodes <= 1'b0;
      settle;
      `CHK(chanSleepStateEnable, 4'h5)
      `CHK(chanSleepVoltageCode, 16'hf0d5)
      `CHK(chanActiveStateEnable, 4'h5)
      `CHK(chanActiveVoltageCode, 16'hf0d5)
   endtask
   task t_run;
      @(posedge clk) sysState <= lvs_pkg::LVS_SYS_RUN;
      settle;
      `CHK(chanOn, 4'h5)
      `CHK(chanPassThrough, 4'h4)
      `CHK(chanRegulate, 4'h1)
      wr(2'h2, lvs_pkg::LVS_FLD_ILIM_EN, 4'h1);
      settle;
      `CHK(switchCurrentLimitEnable, 4'h4)
      `CHK(chanCurrentLimit, 4'h4)
      wr(2'h2, lvs_pkg::LVS_FLD_ACTIVE_EN, 4'h0);
      settle;
      `CHK(chanPullDown, 4'he)
   endtask
   task t_codes;
      for (int i = 0; i < 16; i++)
      begin
         wr(2'h0, lvs_pkg::LVS_FLD_ACTIVE_CODE, 4'(i));
         settle;
         `CHK(chanVoltCode[3:0], 4'(i))
         `CHK(chanMillivolts[12:0], mv[i])
      end
   endtask
   task t_sleep;
      wr(2'h0, lvs_pkg::LVS_FLD_SLEEP_CODE, 4'h9);
      wr(2'h0, lvs_pkg::LVS_FLD_SLEEP_EN, 4'h0);
      @(posedge clk) sysState <= lvs_pkg::LVS_SYS_SLEEP;
      settle;
      `CHK(chanOn, 4'h4)
      `CHK(chanVoltCode[3:0], 4'h9)
   endtask
   task t_hw;
      wr(2'h1, lvs_pkg::LVS_FLD_SLEEP_CODE, 4'h3);
      @(posedge clk) sysState <= lvs_pkg::LVS_SYS_RUN;
      fusedHwSecondChanControl <= 1'b1;
      hwSecondChanEnablePin <= 1'b1;
      hwVoltageChoicePin <= 1'b1;
      settle;
      `CHK({chanOn[1], chanVoltCode[7:4]}, 5'h13)
      @(posedge clk) hwSecondChanEnablePin <= 1'b0;
      hwVoltageChoicePin <= 1'b0;
      settle;
      `CHK({chanOn[1], chanVoltCode[7:4]}, 5'h0d)
   endtask
   task t_tbb;
      @(posedge clk) sysState <= lvs_pkg::LVS_SYS_QUICK_POWERUP_OFF_STATE;
      tryBeforeBuyEnable <= 1'b1;
      settle;
      `CHK({chanWeakPullDown, chanPullDown}, 8'hf0)
   endtask
   // mid-run reset must clear enables and restore the strong pull-down
   task t_reset;
      @(posedge clk) reset <= 1'b1;
      settle;
      `CHK({chanWeakPullDown, chanPullDown, chanActiveStateEnable}, 12'h0f0)
      `CHK(chanMillivolts, {4{13'h05dc}})
      @(posedge clk) reset <= 1'b0;
      settle;
      `CHK({chanWeakPullDown, chanPullDown}, 8'hf0)
   endtask
   task tally_and_finish;
      $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_powerup;
      t_run;
      t_codes;
      t_sleep;
      t_hw;
      t_tbb;
      t_reset;
      tally_and_finish;
   end
endmodule
